/* File: tcs_scan_ctrl.sv */
`timescale 1ns/1ns
`include "tcs_regs.svh"
// Operation
// - Mode bits 3..1 pick continuous, single, offset, range or cold junction calibration.
// - Writing one to start bit 0 launches the selected sequence.
// - With bit 4 set, an external trigger also launches the sequence.
// - Start bit clears itself when each sequence ends.
// - Bit 5 high holds the on-board processor in reset.
// - Fail lamp dark when bit 7 is one, lit when zero.
// - Self-test runs right after every reset before scanning.
// - Self-test covers multiplexer, converter, processor memory, control ports.
// - Channel control bits 7..0 enable each channel for processing.
// - Channel control bits 13..8 select resolution and units.
// - Bits 15..14 choose offset, twos, inverted offset, inverted twos coding.
// - Coding field resets to 01, twos complement.
// - Results right-justified, sign extended through bit 15.
// - Nine 16-bit result registers: eight channels plus cold junction.
// - Calibration adjusts offset or gain then stores it nonvolatile.
// - Calibration runs only with jumper installed, else parameters untouched.
// - Select codes 0-10 thermocouple curves, 11-12 reserved, 13-15 linear.
// - Host sees sixteen contiguous 16-bit registers.
// - Read-only identity register returns a fixed 16-bit code.
module tcs_scan_ctrl
  import tcs_pkg::*;
#(
  parameter int ADC_W = 13
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic             host_sel,
  input  wire logic             host_wr,
  input  wire logic [3:0]       host_addr,
  input  wire logic [15:0]      host_wdata,
  output logic      [15:0]      host_rdata,
  output logic                  host_ack,
  input  wire logic             field_input_connector,
  input  wire logic             cal_jumper,
  input  wire logic [3:0]       selftest_ok,
  output logic                  cpu_reset,
  output logic                  fail_lamp_on,
  output logic      [3:0]       conv_chan,
  output logic                  conv_req,
  input  wire logic             conv_done,
  input  wire logic [ADC_W-1:0] conv_data,
  output logic                  cal_req,
  input  wire logic             cal_done,
  output logic                  nv_write,
  output logic      [5:0]       result_format,
  output logic      [3:0]       curve_select
);
  // ==========================================================
  // Registers
  logic [15:0] csr_q;
  logic [15:0] ccr_q;
  logic [3:0]  sel_q;
  logic        trig_s1_q;
  logic        trig_s2_q;
  logic        trig_s3_q;
  logic [7:0]  bit_cnt_q;
  logic [3:0]  chan_q;
  logic        rd_mem_q;
  logic        wr_pend_q;
  tcs_state_t  state_q;
  logic [15:0] res_word;
  logic [15:0] mem_rdata;
  logic        launch;
  logic        seq_end;
  logic        trig_edge;
  logic        wr_stb;
  tcs_mode_t   mode;

  function automatic logic [15:0] tcs_encode(input logic [ADC_W-1:0] raw, input logic [1:0] coding);
    logic [15:0] w;
    w = {{(16 - ADC_W){raw[ADC_W-1]}}, raw};
    if (!coding[0])
      w[15] = ~w[15];
    if (coding[1])
      w = ~w;
    return w;
  endfunction : tcs_encode

  function automatic logic [3:0] tcs_next_chan(input logic [3:0] from, input logic [7:0] mask);
    logic [3:0] n;
    n = 4'h8;
    for (int i = 7; i >= 0; i--)
      if (mask[i] && (4'(i) >= from))
        n = 4'(i);
    return n;
  endfunction : tcs_next_chan

  assign mode          = tcs_mode_t'(csr_q[`TCS_CSR_MODE_HI:`TCS_CSR_MODE_LO]);
  assign cpu_reset     = csr_q[`TCS_CSR_CPU_RST];
  assign fail_lamp_on  = ~csr_q[`TCS_CSR_LED_OFF];
  assign result_format = ccr_q[`TCS_CCR_RES_HI:`TCS_CCR_RES_LO];
  assign curve_select  = sel_q;
  assign trig_edge     = trig_s2_q & ~trig_s3_q;
  assign launch        = (state_q == TCS_ST_IDLE) && (csr_q[`TCS_CSR_START] ||
                         (csr_q[`TCS_CSR_TRIG_EN] && trig_edge));
  assign seq_end       = (state_q == TCS_ST_DONE);
  assign res_word      = tcs_encode(conv_data, ccr_q[`TCS_CCR_INV:`TCS_CCR_TWOS]);
  assign conv_req      = (state_q == TCS_ST_CONVERT) && (chan_q <= 4'h8);
  assign conv_chan     = chan_q;
  assign cal_req       = (state_q == TCS_ST_CAL);
  // Host holds select through the acknowledge edge; only its first edge writes
  assign wr_stb        = host_sel && host_wr && !wr_pend_q;
  assign nv_write      = cal_req && cal_done;

  // ==========================================================
  // Trigger synchroniser
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
    end
    else
    begin
      trig_s1_q <= field_input_connector;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
    end
  end

  // ==========================================================
  // Sequencer
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q   <= TCS_ST_SELFTEST;
      bit_cnt_q <= 8'h00;
      chan_q    <= 4'h0;
    end
    else
    begin
      case (state_q)
        TCS_ST_SELFTEST:
        begin
          bit_cnt_q <= bit_cnt_q + 8'h01;
          if (bit_cnt_q == `TCS_BIT_CYCLES)
            state_q <= TCS_ST_IDLE;
        end
        TCS_ST_IDLE:
        begin
          if (launch)
          begin
            if (mode == TCS_MODE_CONT || mode == TCS_MODE_SINGLE)
            begin
              chan_q  <= tcs_next_chan(4'h0, ccr_q[`TCS_CCR_MASK_HI:0]);
              state_q <= TCS_ST_CONVERT;
            end
            else if (cal_jumper)
              state_q <= TCS_ST_CAL;
            else
              state_q <= TCS_ST_DONE;
          end
        end
        TCS_ST_CONVERT:
        begin
          if (chan_q > 4'h8)
            state_q <= TCS_ST_DONE;
          else if (conv_done)
          begin
            if (chan_q == 4'h8)
            begin
              if (mode == TCS_MODE_CONT && !cpu_reset)
                chan_q <= tcs_next_chan(4'h0, ccr_q[`TCS_CCR_MASK_HI:0]);
              else
                chan_q <= 4'hF;
            end
            else
              chan_q <= tcs_next_chan(chan_q + 4'h1, ccr_q[`TCS_CCR_MASK_HI:0]);
          end
        end
        TCS_ST_CAL:
        begin
          if (cal_done)
            state_q <= TCS_ST_DONE;
        end
        TCS_ST_DONE:
          state_q <= TCS_ST_IDLE;
        default:
          state_q <= TCS_ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Host register writes
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      csr_q <= `TCS_CSR_RESET;
      ccr_q <= `TCS_CCR_RESET;
      sel_q <= 4'h0;
    end
    else
    begin
      if (wr_stb && host_addr == `TCS_IDX_CSR)
      begin
        csr_q[`TCS_CSR_LED_OFF]                  <= host_wdata[`TCS_CSR_LED_OFF];
        csr_q[`TCS_CSR_CPU_RST:`TCS_CSR_MODE_LO] <= host_wdata[`TCS_CSR_CPU_RST:`TCS_CSR_MODE_LO];
        if (host_wdata[`TCS_CSR_START])
          csr_q[`TCS_CSR_START] <= 1'b1;
      end
      else if (seq_end)
        csr_q[`TCS_CSR_START] <= 1'b0;
      if (state_q == TCS_ST_SELFTEST && bit_cnt_q == `TCS_BIT_CYCLES)
        csr_q[`TCS_CSR_FAIL] <= ~&selftest_ok;
      if (state_q == TCS_ST_IDLE && launch && !csr_q[`TCS_CSR_START])
        csr_q[`TCS_CSR_START] <= 1'b1;
      if (wr_stb && host_addr == `TCS_IDX_CCR)
        ccr_q <= host_wdata;
      if (wr_stb && host_addr == `TCS_IDX_SEL)
        sel_q <= host_wdata[3:0];
    end
  end

  // ==========================================================
  // Host reads; results come from the memory one cycle later
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_mem_q   <= 1'b0;
      wr_pend_q  <= 1'b0;
      host_rdata <= 16'h0000;
    end
    else
    begin
      rd_mem_q  <= host_sel && !host_wr && !rd_mem_q && host_addr >= `TCS_IDX_RES0 &&
                   host_addr <= `TCS_IDX_RES_LAST;
      wr_pend_q <= host_sel && host_wr && !wr_pend_q;
      case (host_addr)
        `TCS_IDX_ID:  host_rdata <= `TCS_BOARD_CODE;
        `TCS_IDX_CSR: host_rdata <= csr_q;
        `TCS_IDX_CCR: host_rdata <= ccr_q;
        `TCS_IDX_SEL: host_rdata <= {12'h000, sel_q};
        default:      host_rdata <= (host_addr > `TCS_IDX_RES_LAST) ? 16'h0000 : mem_rdata;
      endcase
    end
  end

  assign host_ack = rd_mem_q | wr_pend_q |
                    (host_sel && !host_wr && !rd_mem_q &&
                     (host_addr < `TCS_IDX_RES0 || host_addr > `TCS_IDX_RES_LAST));

  tcs_result_mem #(
    .WORDS (9),
    .AW    (4)
  ) u_mem (
    .clock   (clock),
    .resetn  (resetn),
    .wr_en   (conv_req && conv_done),
    .wr_addr (chan_q),
    .wr_data (res_word),
    .rd_addr (host_addr - `TCS_IDX_RES0),
    .rd_data (mem_rdata)
  );

  // ==========================================================
  // Checks
  property p_start_clear;
    @(posedge clock) disable iff (!resetn)
      (seq_end && !(host_sel && host_wr)) |=> !csr_q[`TCS_CSR_START];
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("start bit not cleared");

  property p_lamp;
    @(posedge clock) disable iff (!resetn) fail_lamp_on == !csr_q[`TCS_CSR_LED_OFF];
  endproperty
  a_lamp: assert property (p_lamp) else $error("lamp level wrong");

  property p_cal_gate;
    @(posedge clock) disable iff (!resetn) (launch && !cal_jumper && mode > TCS_MODE_SINGLE) |=> !cal_req;
  endproperty
  a_cal_gate: assert property (p_cal_gate) else $error("calibration ran without jumper");

  sequence s_trig_rise;
    !trig_s2_q ##1 trig_s2_q;
  endsequence
  property p_trig_once;
    @(posedge clock) disable iff (!resetn) (trig_s2_q && trig_s3_q) |-> !trig_edge;
  endproperty
  a_trig_once: assert property (p_trig_once) else $error("held trigger relaunched");

  property p_selftest_first;
    @(posedge clock) disable iff (!resetn) $rose(resetn) |-> state_q == TCS_ST_SELFTEST;
  endproperty
  a_selftest_first: assert property (p_selftest_first) else $error("no self-test after reset");

  property p_nv_only_cal;
    @(posedge clock) disable iff (!resetn) nv_write |-> (cal_jumper || $past(cal_jumper, 1) || cal_req);
  endproperty
  a_nv_only_cal: assert property (p_nv_only_cal) else $error("nonvolatile write outside calibration");

  property p_chan_order;
    @(posedge clock) disable iff (!resetn)
      (conv_req && conv_done && chan_q < 4'h8) |=> (chan_q > $past(chan_q));
  endproperty
  a_chan_order: assert property (p_chan_order) else $error("channel order not ascending");

  property p_twos_default;
    @(posedge clock) $rose(resetn) |-> ccr_q == `TCS_CCR_RESET;
  endproperty
  a_twos_default: assert property (p_twos_default) else $error("channel control reset wrong");
endmodule : tcs_scan_ctrl

/* File: tcs_regs.svh */
`ifndef TCS_REGS_SVH
`define TCS_REGS_SVH

// ==========================================================
// Register word indices (16-word window, 16-bit words)
`define TCS_IDX_ID          4'h0
`define TCS_IDX_CSR         4'h1
`define TCS_IDX_CCR         4'h2
`define TCS_IDX_SEL         4'h3
`define TCS_IDX_RES0        4'h4
`define TCS_IDX_RES_LAST    4'hC

// ==========================================================
// Board control and status fields
`define TCS_CSR_START       0
`define TCS_CSR_MODE_LO     1
`define TCS_CSR_MODE_HI     3
`define TCS_CSR_TRIG_EN     4
`define TCS_CSR_CPU_RST     5
`define TCS_CSR_FAIL        6
`define TCS_CSR_LED_OFF     7
`define TCS_CSR_RESET       16'h0000

// ==========================================================
// Channel control fields
`define TCS_CCR_MASK_HI     7
`define TCS_CCR_RES_LO      8
`define TCS_CCR_RES_HI      13
`define TCS_CCR_TWOS        14
`define TCS_CCR_INV         15
`define TCS_CCR_RESET       16'h40FF

// ==========================================================
// Conversion select codes
`define TCS_SEL_TC_LAST     4'hA
`define TCS_SEL_RSV_LO      4'hB
`define TCS_SEL_RSV_HI      4'hC
`define TCS_SEL_LIN_LO      4'hD

// ==========================================================
// Self-test length and board code (board code value is arbitrary)
`define TCS_BIT_CYCLES      8'h20
`define TCS_BOARD_CODE      16'h5A3C

`endif

/* File: tcs_pkg.sv */
package tcs_pkg;
  typedef enum logic [2:0] {
    TCS_MODE_CONT,
    TCS_MODE_SINGLE,
    TCS_MODE_OFFS_CAL,
    TCS_MODE_RANGE_CAL,
    TCS_MODE_CJ_CAL
  } tcs_mode_t;

  typedef enum logic [1:0] {
    TCS_CODE_OFFS,
    TCS_CODE_TWOS,
    TCS_CODE_OFFS_INV,
    TCS_CODE_TWOS_INV
  } tcs_coding_t;

  typedef enum {
    TCS_ST_SELFTEST,
    TCS_ST_IDLE,
    TCS_ST_CONVERT,
    TCS_ST_CAL,
    TCS_ST_DONE
  } tcs_state_t;
endpackage : tcs_pkg

/* File: tcs_result_mem.sv */
`timescale 1ns/1ns
// ==========================================================
// Result words, one per channel plus cold junction; registered read
module tcs_result_mem #(
  parameter int WORDS = 9,
  parameter int AW    = 4
) (
  input  wire logic          clock,
  input  wire logic          resetn,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [15:0]   wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [15:0]   rd_data
);
  logic [15:0] mem_q [WORDS];

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < WORDS; i++)
        mem_q[i] <= 16'h0000;
    end
    else if (wr_en && (int'(wr_addr) < WORDS))
    begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      rd_data <= 16'h0000;
    else if (int'(rd_addr) < WORDS)
      rd_data <= mem_q[rd_addr];
    else
      rd_data <= 16'h0000;
  end
endmodule : tcs_result_mem

/* File: tcs_conv_model.sv */
`timescale 1ns/1ns
// ==========
// Converter and calibration engine on the processor side
module tcs_conv_model (
  input  wire logic        clock,
  input  wire logic [3:0]  conv_chan,
  input  wire logic        conv_req,
  output logic             conv_done,
  output logic [12:0]      conv_data,
  input  wire logic        cal_req,
  output logic             cal_done,
  input  wire logic [3:0]  lat
);
  logic [3:0] chan_q[$];

  // Requests are looked at on the falling edge so the design's own updates have landed
  initial
  begin
    conv_done = 1'b0;
    conv_data = 13'h0AAA;
    forever
    begin
      @(negedge clock);
      if (conv_req === 1'b1)
      begin
        if (conv_chan < 4'h8)
          chan_q.push_back(conv_chan);
        repeat (lat) @(posedge clock);
        #1;
        conv_done = 1'b1;
        conv_data = {9'h1F0, conv_chan};
        @(posedge clock);
        #1;
        conv_done = 1'b0;
        // Data is not held past the strobe
        conv_data = ~conv_data;
      end
    end
  end

  initial
  begin
    cal_done = 1'b0;
    forever
    begin
      @(negedge clock);
      if (cal_req === 1'b1)
      begin
        repeat (lat) @(posedge clock);
        #1;
        cal_done = 1'b1;
        @(posedge clock);
        #1;
        cal_done = 1'b0;
      end
    end
  end
endmodule : tcs_conv_model

/* File: tcs_scan_ctrl_test.sv */
`timescale 1ns/1ns
`include "tcs_regs.svh"
// ==========
// Host-side bench
module tcs_scan_ctrl_test;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic        host_sel = 1'b0;
  logic        host_wr = 1'b0;
  logic [3:0]  host_addr = 4'h0;
  logic [15:0] host_wdata = 16'h0000;
  logic        field_input_connector = 1'b0;
  logic        cal_jumper = 1'b0;
  logic [3:0]  selftest_ok = 4'hF;
  logic [3:0]  lat = 4'h2;
  logic [15:0] host_rdata;
  logic        host_ack;
  logic        cpu_reset;
  logic        fail_lamp_on;
  logic        conv_req;
  logic        conv_done;
  logic        cal_req;
  logic        cal_done;
  logic        nv_write;
  logic [3:0]  conv_chan;
  logic [3:0]  curve_select;
  logic [12:0] conv_data;
  logic [5:0]  result_format;
  logic [15:0] rq;
  int          errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          nv_n = 0;

  always #2 clock = ~clock;

  tcs_scan_ctrl i_dut (.clock, .resetn, .host_sel, .host_wr, .host_addr, .host_wdata, .host_rdata,
    .host_ack, .field_input_connector, .cal_jumper, .selftest_ok, .cpu_reset, .fail_lamp_on,
    .conv_chan, .conv_req, .conv_done, .conv_data, .cal_req, .cal_done, .nv_write,
    .result_format, .curve_select);

  tcs_conv_model i_model (.clock, .conv_chan, .conv_req, .conv_done, .conv_data, .cal_req,
    .cal_done, .lat);

  always @(negedge clock)
    if (nv_write === 1'b1)
      nv_n++;

  task automatic summarize();
    if (errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize

  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      errors++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : check

  // Select held until the edge after acknowledge; read data holds until the next access
  task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clock);
    #1;
    host_sel = 1'b1;
    host_wr = w;
    host_addr = a;
    host_wdata = d;
    do
      @(negedge clock);
    while (host_ack !== 1'b1 && ++n < 16);
    check("host_ack", 16'h1, {15'h0, host_ack});
    @(posedge clock);
    #1;
    host_sel = 1'b0;
    rq = host_rdata;
  endtask : acc

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e, input string what);
    acc(1'b0, a, 16'h0000);
    check(what, e, rq);
  endtask : rd_chk

  task automatic wait_idle();
    int n;
    n = 0;
    do
    begin
      acc(1'b0, `TCS_IDX_CSR, 16'h0000);
      n++;
    end
    while (rq[0] !== 1'b0 && n < 300);
    check("start bit", 16'h0, {15'h0, rq[0]});
  endtask : wait_idle

  // Long enough for the self-test to finish before the host starts anything
  task automatic do_reset();
    resetn = 1'b0;
    repeat (5) @(posedge clock);
    #1;
    resetn = 1'b1;
    repeat (40) @(posedge clock);
  endtask : do_reset

  task automatic t_reset_vals();
    rd_chk(`TCS_IDX_ID, `TCS_BOARD_CODE, "identity");
    rd_chk(`TCS_IDX_CSR, `TCS_CSR_RESET, "control");
    rd_chk(`TCS_IDX_CCR, `TCS_CCR_RESET, "channel control");
    acc(1'b1, 4'hD, 16'hFFFF);
    rd_chk(4'hD, 16'h0000, "unmapped");
    check("lamp", 16'h1, {15'h0, fail_lamp_on});
  endtask : t_reset_vals

  task automatic t_csr_bits();
    acc(1'b1, `TCS_IDX_CSR, 16'h00E0);
    check("cpu reset", 16'h1, {15'h0, cpu_reset});
    check("lamp", 16'h0, {15'h0, fail_lamp_on});
    rd_chk(`TCS_IDX_CSR, 16'h00A0, "read-only fail bit");
    acc(1'b1, `TCS_IDX_CSR, 16'h0000);
    check("cpu reset", 16'h0, {15'h0, cpu_reset});
    repeat (40) @(posedge clock);
  endtask : t_csr_bits

  task automatic t_ccr();
    for (int c = 0; c < 4; c++)
    begin
      acc(1'b1, `TCS_IDX_CCR, {c[1:0], 6'h15, 8'h5A});
      rd_chk(`TCS_IDX_CCR, {c[1:0], 6'h15, 8'h5A}, "channel control");
      check("format", 16'h0015, {10'h0, result_format});
    end
    acc(1'b1, `TCS_IDX_CCR, 16'h4005);
  endtask : t_ccr

  task automatic t_curve();
    for (int s = 0; s < 16; s++)
      if (s < 11 || s > 12)
      begin
        acc(1'b1, `TCS_IDX_SEL, 16'(s));
        rd_chk(`TCS_IDX_SEL, 16'(s), "curve code");
        check("curve out", 16'(s), {12'h0, curve_select});
      end
  endtask : t_curve

  task automatic t_single();
    i_model.chan_q.delete();
    lat = 4'h3;
    acc(1'b1, `TCS_IDX_CSR, 16'h0003);
    wait_idle();
    check("channels seen", 16'h2, 16'(i_model.chan_q.size()));
    check("first channel", 16'h0, {12'h0, i_model.chan_q[0]});
    check("second channel", 16'h2, {12'h0, i_model.chan_q[1]});
    rd_chk(`TCS_IDX_RES0, 16'hFF00, "result 0");
    rd_chk(`TCS_IDX_RES0 + 4'h2, 16'hFF02, "result 2");
  endtask : t_single

  // Trigger level is held long after its edge: a level-sensitive launch would rescan
  task automatic t_trig();
    i_model.chan_q.delete();
    lat = 4'h0;
    acc(1'b1, `TCS_IDX_CSR, 16'h0012);
    field_input_connector = 1'b1;
    repeat (60) @(posedge clock);
    #1;
    wait_idle();
    field_input_connector = 1'b0;
    check("trigger scans", 16'h2, 16'(i_model.chan_q.size()));
    acc(1'b1, `TCS_IDX_CSR, 16'h0000);
  endtask : t_trig

  task automatic t_cal();
    lat = 4'h4;
    for (int m = 2; m < 5; m++)
      for (int j = 0; j < 2; j++)
      begin
        cal_jumper = j[0];
        nv_n = 0;
        acc(1'b1, `TCS_IDX_CSR, 16'(m * 2 + 1));
        wait_idle();
        check("nv writes", 16'(j), 16'(nv_n));
      end
    cal_jumper = 1'b0;
  endtask : t_cal

  task automatic t_cont();
    i_model.chan_q.delete();
    acc(1'b1, `TCS_IDX_CSR, 16'h0001);
    repeat (100) @(posedge clock);
    check("rescans", 16'h1, 16'(i_model.chan_q.size() > 4));
    acc(1'b1, `TCS_IDX_CSR, 16'h0020);
    acc(1'b1, `TCS_IDX_CSR, 16'h0000);
  endtask : t_cont

  task automatic t_selftest();
    for (int i = 0; i < 4; i++)
    begin
      selftest_ok = ~(4'h1 << i);
      do_reset();
      rd_chk(`TCS_IDX_CSR, 16'h0040, "self-test fail");
    end
    selftest_ok = 4'hF;
    do_reset();
    rd_chk(`TCS_IDX_CSR, 16'h0000, "self-test pass");
  endtask : t_selftest

  initial
  begin
    do_reset();
    t_reset_vals();
    t_csr_bits();
    t_ccr();
    t_curve();
    t_single();
    t_trig();
    t_cal();
    t_cont();
    t_selftest();
    summarize();
  end
endmodule : tcs_scan_ctrl_test
